// ---- design/backup_rtc_counter.sv ----
/*
 * backup real time clock: 48-bit seconds.fraction counter on the slow
 * clock, staged load, alarm wake-up, rate trim, interrupt status and the
 * backup sram, all behind an axi4-lite slave.
 * assumes the slow clock is a plain input sampled in the bus clock domain
 * and one write and one read at most in flight from the master.
 */
`timescale 1ns/1ps
`default_nettype none
module backup_rtc_counter (
	input  wire logic        i_clk,         // bus clock, 125 mhz
	input  wire logic        i_rst_n,       // async reset, active low
	input  wire logic        i_ce,          // clock enable, freezes all state
	input  wire logic        i_slow_clk,    // 32.768 khz slow clock
	input  wire logic [13:0] i_axi_awaddr,  // write address
	input  wire logic        i_axi_awvalid, // write address valid
	output logic             o_axi_awready, // write address ready
	input  wire logic [31:0] i_axi_wdata,   // write data
	input  wire logic [3:0]  i_axi_wstrb,   // write byte strobes
	input  wire logic        i_axi_wvalid,  // write data valid
	output logic             o_axi_wready,  // write data ready
	output logic      [1:0]  o_axi_bresp,   // write response
	output logic             o_axi_bvalid,  // write response valid
	input  wire logic        i_axi_bready,  // write response ready
	input  wire logic [13:0] i_axi_araddr,  // read address
	input  wire logic        i_axi_arvalid, // read address valid
	output logic             o_axi_arready, // read address ready
	output logic      [31:0] o_axi_rdata,   // read data
	output logic      [1:0]  o_axi_rresp,   // read response
	output logic             o_axi_rvalid,  // read data valid
	input  wire logic        i_axi_rready,  // read data ready
	output logic             o_irq,         // level interrupt
	output logic             o_wakeup       // alarm wake-up level
);
	// ----------------------------------------------------------------
	// declarations
	// ----------------------------------------------------------------
	logic                    tick;
	logic [47:0]             count;
	logic [47:0]             step;
	logic [31:0]             ld_sec;
	logic [15:0]             ld_frac;
	logic [31:0]             alarm;
	logic [15:0]             trim_intv;
	logic [15:0]             trim_cnt;
	logic                    trim_due;
	logic                    ctrl_en;
	logic                    load_pend;
	logic                    trim_en;
	logic                    trim_up;
	logic                    alarm_en;
	logic                    alarm_match;
	logic                    alarm_hit;
	logic [1:0]              irq_stat;
	logic [1:0]              irq_mask;
	logic [1:0]              irq_set;
	logic                    aw_got;
	logic                    w_got;
	logic [13:0]             waddr;
	logic [31:0]             wdata;
	logic [3:0]              wstrb;
	logic                    wr_fire;
	logic                    wr_ctrl;
	logic                    wr_mapped;
	logic [13:0]             raddr;
	logic                    rd_mapped;
	logic [31:0]             sram_q;
	logic [31:0]             reg_rdata;
	rtc_pkg::rd_state_t      rd_state;

	// ----------------------------------------------------------------
	// slow clock tick and backup sram
	// ----------------------------------------------------------------
	slow_tick_sync u_tick (
		.i_clk      (i_clk),
		.i_rst_n    (i_rst_n),
		.i_ce       (i_ce),
		.i_slow_clk (i_slow_clk),
		.o_tick     (tick)
	);

	backup_sram u_sram (
		.i_clk      (i_clk),
		.i_ce       (i_ce),
		.i_wr_en    (wr_fire && rtc_pkg::is_sram(waddr)), // [R12]
		.i_wr_addr  (waddr[12:2]),
		.i_wr_data  (wdata),
		.i_wr_strb  (wstrb),
		.i_rd_addr  (raddr[12:2]),
		.o_rd_data  (sram_q)
	);

	// ----------------------------------------------------------------
	// write channel
	// ----------------------------------------------------------------
	assign wr_fire = aw_got && w_got && !o_axi_bvalid;
	assign wr_ctrl = wr_fire && (waddr == rtc_pkg::OFS_CTRL);

	// address and data are taken in either order; the response waits for both
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			aw_got        <= 1'b0;
			w_got         <= 1'b0;
			waddr         <= 14'h0000;
			wdata         <= 32'h0000_0000;
			wstrb         <= 4'h0;
			o_axi_awready <= 1'b1;
			o_axi_wready  <= 1'b1;
			o_axi_bvalid  <= 1'b0;
			o_axi_bresp   <= rtc_pkg::RESP_OKAY;
		end else if (i_ce) begin
			if (i_axi_awvalid && o_axi_awready) begin
				aw_got        <= 1'b1;
				waddr         <= i_axi_awaddr;
				o_axi_awready <= 1'b0;
			end
			if (i_axi_wvalid && o_axi_wready) begin
				w_got        <= 1'b1;
				wdata        <= i_axi_wdata;
				wstrb        <= i_axi_wstrb;
				o_axi_wready <= 1'b0;
			end
			if (wr_fire) begin
				o_axi_bvalid <= 1'b1;
				o_axi_bresp  <= wr_mapped ? rtc_pkg::RESP_OKAY : rtc_pkg::RESP_SLVERR;
			end
			if (o_axi_bvalid && i_axi_bready) begin
				o_axi_bvalid  <= 1'b0;
				aw_got        <= 1'b0;
				w_got         <= 1'b0;
				o_axi_awready <= 1'b1;
				o_axi_wready  <= 1'b1;
			end
		end
	end

	// writable offsets; the count registers are read only and answer with an error
	always_comb begin
		unique case (waddr)
			rtc_pkg::OFS_CTRL, rtc_pkg::OFS_LD_SEC, rtc_pkg::OFS_LD_FRAC, rtc_pkg::OFS_ALARM,
			rtc_pkg::OFS_TRIM, rtc_pkg::OFS_IRQ_STAT, rtc_pkg::OFS_IRQ_MASK: wr_mapped = 1'b1;
			default: wr_mapped = rtc_pkg::is_sram(waddr);
		endcase
	end

	// ----------------------------------------------------------------
	// software registers
	// ----------------------------------------------------------------
	// staging, alarm, trim and mask registers; staging may change while a load waits
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			ld_sec    <= 32'h0000_0000;
			ld_frac   <= 16'h0000;
			alarm     <= 32'h0000_0000;
			trim_intv <= rtc_pkg::TRIM_RST;
			irq_mask  <= 2'h0;
		end else if (i_ce && wr_fire) begin
			unique case (waddr)
				rtc_pkg::OFS_LD_SEC:   ld_sec    <= rtc_pkg::merge_strb(ld_sec, wdata, wstrb); // [R5]
				rtc_pkg::OFS_LD_FRAC:  ld_frac   <= 16'(rtc_pkg::merge_strb({16'h0000, ld_frac}, wdata, wstrb)); // [R6]
				rtc_pkg::OFS_ALARM:    alarm     <= rtc_pkg::merge_strb(alarm, wdata, wstrb);
				rtc_pkg::OFS_TRIM:     trim_intv <= 16'(rtc_pkg::merge_strb({16'h0000, trim_intv}, wdata, wstrb));
				rtc_pkg::OFS_IRQ_MASK: irq_mask  <= 2'(rtc_pkg::merge_strb({30'h0000_0000, irq_mask}, wdata, wstrb));
				default: ;
			endcase
		end
	end

	// control bits; a written one arms the load, a written zero leaves it alone
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			ctrl_en   <= 1'b0;
			load_pend <= 1'b0;
			trim_en   <= 1'b0;
			trim_up   <= 1'b0;
			alarm_en  <= 1'b0;
		end else if (i_ce) begin
			if (wr_ctrl && wstrb[0]) begin
				ctrl_en  <= wdata[rtc_pkg::CTRL_EN]; // [R4]
				trim_en  <= wdata[rtc_pkg::CTRL_TRIM_EN];
				trim_up  <= wdata[rtc_pkg::CTRL_TRIM_UP];
				alarm_en <= wdata[rtc_pkg::CTRL_ALM_EN];
			end
			// a fresh arm in the commit cycle wins over the hardware clear
			if (wr_ctrl && wstrb[0] && wdata[rtc_pkg::CTRL_LOAD]) begin
				load_pend <= 1'b1;
			end else if (tick) begin
				load_pend <= 1'b0; // [R8]
			end
		end
	end

	// ----------------------------------------------------------------
	// time counter
	// ----------------------------------------------------------------
	// once every trim interval plus one ticks, one tick counts one fraction lsb (TRIM_ADJ, half a fraction step) more or less
	// at or past the interval, so a smaller interval written mid-count takes effect at once
	assign trim_due = trim_en && (trim_cnt >= trim_intv);
	assign step     = !trim_due ? rtc_pkg::FRAC_STEP :
	                  trim_up   ? rtc_pkg::FRAC_STEP + rtc_pkg::TRIM_ADJ :
	                              rtc_pkg::FRAC_STEP - rtc_pkg::TRIM_ADJ; // [R10]

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			trim_cnt <= 16'h0000;
		end else if (i_ce && !trim_en) begin
			trim_cnt <= 16'h0000; // idle trim restarts its interval from zero
		end else if (i_ce && tick && ctrl_en && !load_pend) begin
			trim_cnt <= trim_due ? 16'h0000 : trim_cnt + 16'h0001; // [R10]
		end
	end

	// the load waits for a slow tick, so software sees the update in slow time
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			count <= 48'h0000_0000_0000;
		end else if (i_ce && tick) begin // [R14]
			if (load_pend) begin
				count <= {ld_sec, ld_frac}; // [R7]
			end else if (ctrl_en) begin
				count <= count + step; // [R1] [R2] [R11]
			end
		end
	end

	// ----------------------------------------------------------------
	// alarm and interrupts
	// ----------------------------------------------------------------
	assign alarm_hit = alarm_en && (count[47:16] == alarm) && !alarm_match; // [R13]
	assign irq_set   = {i_ce && tick && load_pend, alarm_hit};

	// the match is only an event on its first cycle
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			alarm_match <= 1'b0;
		end else if (i_ce) begin
			alarm_match <= alarm_en && (count[47:16] == alarm);
		end
	end

	// sticky status, write one to clear; a new event in the clear cycle stays set
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			irq_stat <= 2'h0;
		end else if (i_ce) begin
			if (wr_fire && waddr == rtc_pkg::OFS_IRQ_STAT && wstrb[0]) begin
				irq_stat <= (irq_stat & ~wdata[1:0]) | irq_set; // [R13]
			end else begin
				irq_stat <= irq_stat | irq_set; // [R9]
			end
		end
	end

	// the wake-up ignores the mask: it must reach the power controller regardless
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_irq    <= 1'b0;
			o_wakeup <= 1'b0;
		end else if (i_ce) begin
			o_irq    <= |(irq_stat & irq_mask);
			o_wakeup <= irq_stat[rtc_pkg::IRQ_ALARM]; // [R9]
		end
	end

	// ----------------------------------------------------------------
	// read channel
	// ----------------------------------------------------------------
	// each count half is its own word; no latch ties one read to the other
	always_comb begin
		rd_mapped = 1'b1;
		unique case (raddr)
			rtc_pkg::OFS_CTRL:     reg_rdata = {27'h000_0000, alarm_en, trim_up, trim_en, load_pend, ctrl_en};
			rtc_pkg::OFS_SEC:      reg_rdata = count[47:16]; // [R3]
			rtc_pkg::OFS_FRAC:     reg_rdata = {16'h0000, count[15:0]}; // [R3]
			rtc_pkg::OFS_LD_SEC:   reg_rdata = ld_sec;
			rtc_pkg::OFS_LD_FRAC:  reg_rdata = {16'h0000, ld_frac};
			rtc_pkg::OFS_ALARM:    reg_rdata = alarm;
			rtc_pkg::OFS_TRIM:     reg_rdata = {16'h0000, trim_intv};
			rtc_pkg::OFS_IRQ_STAT: reg_rdata = {30'h0000_0000, irq_stat};
			rtc_pkg::OFS_IRQ_MASK: reg_rdata = {30'h0000_0000, irq_mask};
			default: begin
				reg_rdata = rtc_pkg::is_sram(raddr) ? sram_q : 32'h0000_0000;
				rd_mapped = rtc_pkg::is_sram(raddr);
			end
		endcase
	end

	// the wait state covers the sram read latency for every address alike
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			rd_state      <= rtc_pkg::RD_IDLE;
			raddr         <= 14'h0000;
			o_axi_arready <= 1'b1;
			o_axi_rvalid  <= 1'b0;
			o_axi_rdata   <= 32'h0000_0000;
			o_axi_rresp   <= rtc_pkg::RESP_OKAY;
		end else if (i_ce) begin
			unique case (rd_state)
				rtc_pkg::RD_IDLE: begin
					if (i_axi_arvalid) begin
						raddr         <= i_axi_araddr;
						o_axi_arready <= 1'b0;
						rd_state      <= rtc_pkg::RD_WAIT;
					end
				end
				rtc_pkg::RD_WAIT: begin
					rd_state <= rtc_pkg::RD_DATA;
				end
				rtc_pkg::RD_DATA: begin
					o_axi_rdata  <= reg_rdata;
					o_axi_rresp  <= rd_mapped ? rtc_pkg::RESP_OKAY : rtc_pkg::RESP_SLVERR;
					o_axi_rvalid <= 1'b1;
					rd_state     <= rtc_pkg::RD_RESP;
				end
				rtc_pkg::RD_RESP: begin
					if (i_axi_rready) begin
						o_axi_rvalid  <= 1'b0;
						o_axi_arready <= 1'b1;
						rd_state      <= rtc_pkg::RD_IDLE;
					end
				end
				default: begin
					rd_state      <= rtc_pkg::RD_IDLE;
					o_axi_arready <= 1'b1;
					o_axi_rvalid  <= 1'b0;
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// assertions and covers
	// ----------------------------------------------------------------
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_rst_n);

	AST_COUNT_ADV: assert property (i_ce && tick && ctrl_en && !load_pend && !trim_en // [R1]
		|=> count == $past(count) + rtc_pkg::FRAC_STEP)
		else $error("counter did not advance by one step on a tick");
	AST_FRAC_CARRY: assert property (i_ce && tick && ctrl_en && !load_pend && !trim_en && (&count[15:1]) // [R2]
		|=> count[47:16] == $past(count[47:16]) + 32'h0000_0001 && count[15:1] == 15'h0000)
		else $error("fraction overflow did not carry into seconds");
	AST_SEC_READ: assert property ($rose(o_axi_rvalid) && raddr == rtc_pkg::OFS_SEC // [R3]
		|-> o_axi_rdata == $past(count[47:16]))
		else $error("seconds read returned the wrong value");
	AST_STOP_HOLDS: assert property (!ctrl_en && !load_pend ##1 !ctrl_en && !load_pend // [R4]
		|-> count == $past(count))
		else $error("stopped counter changed");
	AST_LOAD_COMMIT: assert property (i_ce && tick && load_pend // [R7]
		|=> count == {$past(ld_sec), $past(ld_frac)})
		else $error("load did not copy both staging registers");
	AST_LOAD_CLEAR: assert property (i_ce && tick && load_pend && !wr_ctrl // [R8]
		|=> !load_pend && irq_stat[rtc_pkg::IRQ_LOADED])
		else $error("load bit not cleared after commit");
	AST_ALARM_WAKE: assert property (i_ce && alarm_hit // [R9]
		|=> irq_stat[rtc_pkg::IRQ_ALARM] ##1 o_wakeup || !i_ce)
		else $error("alarm match did not raise wake-up");
	AST_ALARM_STICKY: assert property (irq_stat[rtc_pkg::IRQ_ALARM] && !(wr_fire && waddr == rtc_pkg::OFS_IRQ_STAT) // [R13]
		|=> irq_stat[rtc_pkg::IRQ_ALARM])
		else $error("alarm flag dropped without a clear");
	AST_TRIM_STEP: assert property (i_ce && tick && ctrl_en && !load_pend && trim_due && trim_up // [R10]
		|=> count == $past(count) + rtc_pkg::FRAC_STEP + rtc_pkg::TRIM_ADJ)
		else $error("trim did not add the extra step");
	AST_TICK_ONLY: assert property (!tick || !i_ce // [R14]
		|=> count == $past(count))
		else $error("counter changed between slow ticks");

	COV_LOAD: cover property (i_ce && tick && load_pend);
	COV_ALARM: cover property (i_ce && alarm_hit ##[1:4] o_wakeup);
	COV_TRIM: cover property (i_ce && tick && ctrl_en && trim_due);
	COV_SRAM_RD: cover property ($rose(o_axi_rvalid) && rtc_pkg::is_sram(raddr));
endmodule
`default_nettype wire

// ---- design/backup_sram.sv ----
/*
 * 8 KB backup sram as 2048 words of 32 bits, with byte strobes on write
 * and one cycle of read latency.
 * assumes it sits in the always-on supply; contents are never reset.
 */
`timescale 1ns/1ps
`default_nettype none
module backup_sram (
	input  wire logic        i_clk,     // bus clock
	input  wire logic        i_ce,      // clock enable
	input  wire logic        i_wr_en,   // write strobe
	input  wire logic [10:0] i_wr_addr, // write word index
	input  wire logic [31:0] i_wr_data, // write data
	input  wire logic [3:0]  i_wr_strb, // byte lanes
	input  wire logic [10:0] i_rd_addr, // read word index
	output logic      [31:0] o_rd_data  // read data, one cycle later
);
	logic [31:0] mem [2**rtc_pkg::SRAM_AW];

	// no reset on purpose: the array must survive a system reset
	always_ff @(posedge i_clk) begin
		if (i_ce) begin
			if (i_wr_en) begin
				mem[i_wr_addr] <= rtc_pkg::merge_strb(mem[i_wr_addr], i_wr_data, i_wr_strb); // [R12]
			end
			o_rd_data <= mem[i_rd_addr];
		end
	end
endmodule
`default_nettype wire

// ---- design/rtc_pkg.sv ----
/*
 * shared constants for the backup real time clock: register map, field
 * positions, reset values, counting steps and the read state encoding.
 * assumes a 32-bit axi4-lite slave with 14 address bits and one aligned
 * word per register; the backup sram sits in the upper half of the map.
 */
// Overview of operation
// [R1] a 48-bit time counter advances once per slow clock cycle while enabled.
// [R2] the upper 32 bits count whole seconds, the lower 16 bits the fraction, which carries into the seconds.
// [R3] software reads the seconds and the fraction as two separate, independent registers.
// [R4] once enabled, the counter can be stopped again and then holds its value.
// [R5] a 32-bit writable staging register holds the seconds value to be loaded.
// [R6] a 16-bit writable staging register holds the fraction to be loaded.
// [R7] setting the load bit copies both staging registers into the full counter in one update.
// [R8] hardware clears the load bit once the update is done, and software polls for that clear.
// [R9] when the running time reaches the programmed alarm value a wake-up indication is raised.
// [R10] a trimming adjustment of the counting rate compensates for crystal frequency error.
// [R11] the counter keeps running whatever the main system does, as it lives in an always-on domain; but i_rst_n clears it and a low i_ce freezes it.
// [R12] the always-on domain holds an 8 KB backup sram that keeps its contents.
// [R13] the alarm compares against the seconds count and sets a sticky flag that software clears by writing.
// [R14] bus writes to the staging registers and the load bit reach the counter only at a slow clock tick.
package rtc_pkg;

	// ----------------------------------------------------------------
	// bus geometry
	// ----------------------------------------------------------------
	localparam int              ADDR_W       = 14;
	localparam int              DATA_W       = 32;
	localparam logic [1:0]      RESP_OKAY    = 2'h0;
	localparam logic [1:0]      RESP_SLVERR  = 2'h2;

	// ----------------------------------------------------------------
	// register byte offsets
	// ----------------------------------------------------------------
	localparam logic [13:0]     OFS_CTRL     = 14'h0000;
	localparam logic [13:0]     OFS_SEC      = 14'h0004;
	localparam logic [13:0]     OFS_FRAC     = 14'h0008;
	localparam logic [13:0]     OFS_LD_SEC   = 14'h000C;
	localparam logic [13:0]     OFS_LD_FRAC  = 14'h0010;
	localparam logic [13:0]     OFS_ALARM    = 14'h0014;
	localparam logic [13:0]     OFS_TRIM     = 14'h0018;
	localparam logic [13:0]     OFS_IRQ_STAT = 14'h001C;
	localparam logic [13:0]     OFS_IRQ_MASK = 14'h0020;
	localparam int              SRAM_SEL_BIT = 13;
	localparam int              SRAM_AW      = 11;

	// ----------------------------------------------------------------
	// control and interrupt fields
	// ----------------------------------------------------------------
	localparam int              CTRL_EN      = 0;
	localparam int              CTRL_LOAD    = 1;
	localparam int              CTRL_TRIM_EN = 2;
	localparam int              CTRL_TRIM_UP = 3;
	localparam int              CTRL_ALM_EN  = 4;
	localparam int              IRQ_W        = 2;
	localparam int              IRQ_ALARM    = 0;
	localparam int              IRQ_LOADED   = 1;
	localparam logic [15:0]     TRIM_RST     = 16'hFFFF;

	// ----------------------------------------------------------------
	// counting: the fraction spans one second at the slow clock rate
	// ----------------------------------------------------------------
	localparam int              SLOW_HZ      = 32768;
	localparam int              FRAC_ONE_SEC = 65536;
	localparam logic [47:0]     FRAC_STEP    = 48'(FRAC_ONE_SEC / SLOW_HZ);
	localparam logic [47:0]     TRIM_ADJ     = 48'h0000_0000_0001;

	typedef enum logic [3:0] {
		RD_IDLE = 4'b0001,
		RD_WAIT = 4'b0010,
		RD_DATA = 4'b0100,
		RD_RESP = 4'b1000
	} rd_state_t;

	// byte-lane merge for strobed writes
	function automatic logic [31:0] merge_strb(input logic [31:0] old, input logic [31:0] data,
			input logic [3:0] strb);
		logic [31:0] res;
		res = old;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				res[i*8 +: 8] = data[i*8 +: 8];
			end
		end
		return res;
	endfunction

	// the backup sram owns the upper half of the address space
	function automatic logic is_sram(input logic [13:0] addr);
		return addr[SRAM_SEL_BIT];
	endfunction

endpackage

// ---- design/slow_tick_sync.sv ----
/*
 * brings the 32.768 khz slow clock into the bus clock domain and turns
 * each of its rising edges into a one-cycle tick.
 * assumes the bus clock runs far faster than the slow clock.
 */
`timescale 1ns/1ps
`default_nettype none
module slow_tick_sync (
	input  wire logic i_clk,      // bus clock
	input  wire logic i_rst_n,    // async reset, active low
	input  wire logic i_ce,       // clock enable
	input  wire logic i_slow_clk, // slow clock level
	output logic      o_tick      // one pulse per slow rising edge
);
	logic meta;
	logic sync;
	logic sync_d;

	// ----------------------------------------------------------------
	// two-flop synchroniser, then an edge detector on the stable copy
	// ----------------------------------------------------------------
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			meta   <= 1'b0;
			sync   <= 1'b0;
			sync_d <= 1'b0;
			o_tick <= 1'b0;
		end else if (i_ce) begin
			meta   <= i_slow_clk;
			sync   <= meta;
			sync_d <= sync;
			o_tick <= sync & ~sync_d;
		end
	end
endmodule
`default_nettype wire

// ---- dv/tb.sv ----
/*
 * self-checking bench for the backup real time clock, driven over axi4-lite.
 * assumes the package and design files compile first; assertions live in the design.
 */
`timescale 1ns/1ps
`default_nettype none
module tb;
	logic        i_clk, i_rst_n, i_ce, i_slow_clk, awvalid, wvalid, bready, arvalid, rready;
	logic        awready, wready, bvalid, arready, rvalid, o_irq, o_wakeup;
	logic [13:0] awaddr, araddr;
	logic [31:0] wdata, rdata, d, s;
	logic [3:0]  wstrb;
	logic [1:0]  bresp, rresp, resp;
	logic [47:0] t;
	int          n_fail, tests_run, k;

	backup_rtc_counter u_backup_rtc_counter (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_ce(i_ce),
		.i_slow_clk(i_slow_clk), .i_axi_awaddr(awaddr), .i_axi_awvalid(awvalid), .o_axi_awready(awready),
		.i_axi_wdata(wdata), .i_axi_wstrb(wstrb), .i_axi_wvalid(wvalid), .o_axi_wready(wready),
		.o_axi_bresp(bresp), .o_axi_bvalid(bvalid), .i_axi_bready(bready), .i_axi_araddr(araddr),
		.i_axi_arvalid(arvalid), .o_axi_arready(arready), .o_axi_rdata(rdata), .o_axi_rresp(rresp),
		.o_axi_rvalid(rvalid), .i_axi_rready(rready), .o_irq(o_irq), .o_wakeup(o_wakeup));

	// ----------------------------------------------------------------
	// clock, comparison and bus tasks
	// ----------------------------------------------------------------
	initial begin
		i_clk = 0;
		forever #4 i_clk = ~i_clk;
	end

	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			n_fail++;
			$display("[ERR] %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	// address and data offered together, each dropped once its ready is seen
	task automatic wr(input logic [13:0] a, input logic [31:0] v);
		@(posedge i_clk);
		awaddr <= a;
		wdata <= v;
		awvalid <= 1;
		wvalid <= 1;
		bready <= 1;
		do begin
			@(posedge i_clk);
			if (awready) awvalid <= 0;
			if (wready) wvalid <= 0;
		end while (!bvalid); // only the watchdog ends a hang
		resp = bresp;
		bready <= 0;
	endtask

	task automatic rd(input logic [13:0] a);
		@(posedge i_clk);
		araddr <= a;
		arvalid <= 1;
		rready <= 1;
		do begin
			@(posedge i_clk);
			if (arready) arvalid <= 0;
		end while (!rvalid); // only the watchdog ends a hang
		d = rdata;
		resp = rresp;
		rready <= 0;
	endtask

	task automatic rc(input logic [13:0] a, input logic [31:0] exp, input string nm);
		rd(a);
		chk(nm, d, exp);
		chk("rresp", {30'h0, resp}, {30'h0, rtc_pkg::RESP_OKAY});
	endtask

	// each slow period is 17 bus cycles, long enough for the tick to land
	task automatic slow(input int n);
		repeat (n) begin
			@(posedge i_clk);
			i_slow_clk <= 1;
			repeat (8) @(posedge i_clk);
			i_slow_clk <= 0;
			repeat (8) @(posedge i_clk);
		end
	endtask

	function automatic logic [47:0] adv(input logic [47:0] c, input int steps);
		return c + 48'(steps);
	endfunction

	task automatic tally_and_finish();
		$display("comparisons %0d mismatches %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask

	// ----------------------------------------------------------------
	// watchdog: the whole run needs well under 20000 cycles
	// ----------------------------------------------------------------
	initial begin
		#(8 * 20000);
		n_fail++;
		tally_and_finish();
	end

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		{i_rst_n, i_slow_clk, awvalid, wvalid, bready, arvalid, rready, awaddr, araddr, wdata} = '0;
		wstrb = 4'hF;
		i_ce = 1;
		void'($urandom(32'hcaad1667));
		repeat (5) @(posedge i_clk);
		i_rst_n <= 1;
		chk("irq", {31'h0, o_irq}, 32'h0);
		rc(rtc_pkg::OFS_CTRL, 32'h0, "ctrl");
		rc(rtc_pkg::OFS_TRIM, 32'h0000_FFFF, "trim");
		rd(14'h0024);
		chk("gap", {30'h0, resp}, {30'h0, rtc_pkg::RESP_SLVERR});
		wr(rtc_pkg::OFS_SEC, 32'h1);
		chk("sec ro", {30'h0, resp}, {30'h0, rtc_pkg::RESP_SLVERR});
		// staged load commits at a tick, then the load bit clears itself
		s = $urandom;
		wr(rtc_pkg::OFS_LD_SEC, s);
		wr(rtc_pkg::OFS_LD_FRAC, 32'h0000_FFFC);
		wr(rtc_pkg::OFS_IRQ_MASK, 32'h3);
		wr(rtc_pkg::OFS_CTRL, 32'h2);
		rc(rtc_pkg::OFS_CTRL, 32'h2, "armed");
		slow(1);
		for (k = 0; k < 20 && d[1] !== 1'b0; k++) rd(rtc_pkg::OFS_CTRL);
		chk("load clr", d, 32'h0);
		rc(rtc_pkg::OFS_SEC, s, "sec ld");
		rc(rtc_pkg::OFS_FRAC, 32'h0000_FFFC, "frac ld");
		chk("irq ld", {31'h0, o_irq}, 32'h1);
		wr(rtc_pkg::OFS_IRQ_STAT, 32'h2);
		rc(rtc_pkg::OFS_IRQ_STAT, 32'h0, "w1c");
		chk("irq clr", {31'h0, o_irq}, 32'h0);
		// four ticks carry the fraction into the seconds, then stop holds
		wr(rtc_pkg::OFS_CTRL, 32'h1);
		slow(4);
		wr(rtc_pkg::OFS_CTRL, 32'h0);
		t = adv({s, 16'hFFFC}, 8);
		rc(rtc_pkg::OFS_SEC, t[47:16], "sec run");
		rc(rtc_pkg::OFS_FRAC, {16'h0, t[15:0]}, "frac run");
		slow(2);
		rc(rtc_pkg::OFS_FRAC, {16'h0, t[15:0]}, "stopped");
		// alarm one tick after a fresh load
		wr(rtc_pkg::OFS_ALARM, s + 2);
		wr(rtc_pkg::OFS_LD_SEC, s + 1);
		wr(rtc_pkg::OFS_LD_FRAC, 32'h0000_FFFE);
		wr(rtc_pkg::OFS_IRQ_MASK, 32'h1);
		wr(rtc_pkg::OFS_CTRL, 32'h13);
		slow(1);
		chk("no wake", {31'h0, o_wakeup}, 32'h0);
		slow(1);
		chk("wake", {31'h0, o_wakeup}, 32'h1);
		chk("irq alm", {31'h0, o_irq}, 32'h1);
		wr(rtc_pkg::OFS_CTRL, 32'h0);
		rc(rtc_pkg::OFS_IRQ_STAT, 32'h3, "sticky");
		wr(rtc_pkg::OFS_IRQ_STAT, 32'h3);
		repeat (2) @(posedge i_clk);
		chk("wake clr", {31'h0, o_wakeup}, 32'h0);
		// trim interval 1: every second tick steps by 3 (up) or 1 (down)
		wr(rtc_pkg::OFS_TRIM, 32'h1);
		wr(rtc_pkg::OFS_CTRL, 32'hD);
		slow(2);
		rc(rtc_pkg::OFS_FRAC, 32'h0000_0005, "trim up");
		wr(rtc_pkg::OFS_CTRL, 32'h5);
		slow(2);
		wr(rtc_pkg::OFS_CTRL, 32'h0);
		rc(rtc_pkg::OFS_FRAC, 32'h0000_0008, "trim");
		// a low clock enable freezes the tick path and the running counter
		wr(rtc_pkg::OFS_CTRL, 32'h1);
		i_ce <= 0;
		slow(2);
		i_ce <= 1;
		rc(rtc_pkg::OFS_FRAC, 32'h0000_0008, "ce hold");
		wr(rtc_pkg::OFS_CTRL, 32'h0);
		// backup sram words at random places
		repeat (4) begin
			k = $urandom_range(2047);
			s = $urandom;
			wr(14'h2000 + 14'(k * 4), s);
			rc(14'h2000 + 14'(k * 4), s, "sram");
		end
		tally_and_finish();
	end
endmodule
`default_nettype wire
